// ### src/dpsr_pkg.sv
// Shared widths, lane layout and state encodings of the dual port burst SRAM model
package dpsr_pkg;
	localparam int ADDR_W = 18;
	localparam int WORD_ADDR_W = ADDR_W + 1;
	localparam int LANE_W = 9;
	localparam int LANES = 4;
	localparam int DATA_W = LANE_W * LANES;
	localparam int BURST_LEN = 2;
	localparam int BUF_DEPTH = 2;
	localparam int CNT_W = 2;
	localparam logic BURST_OFS0 = 1'h0;
	localparam logic BURST_OFS1 = 1'h1;
	localparam logic [CNT_W-1:0] CNT_EMPTY = 2'h0;
	localparam logic [CNT_W-1:0] CNT_ONE = 2'h1;
	localparam logic [CNT_W-1:0] CNT_FULL = 2'h2;
	localparam logic [LANES-1:0] MASK_NONE = 4'hF;
	typedef enum logic [1:0] {RP_IDLE, RP_W0, RP_W1} dpsr_rp_t;
	typedef enum logic {WR_IDLE, WR_ADDR} dpsr_wr_t;
endpackage

// ### src/dpsr_top.sv
// Dual port two-word burst SRAM: sequencers, write forwarding, output buffer and array
// Notes on behaviour
// RL1: Each active-low lane mask gates its own nine-bit lane of a written word.
// RL2: Address gets an internal low bit; offsets 0 then 1, burst ends after two.
// RL3: Read and write sequencers run independently and may overlap.
// RL4: Low fetch select starts a read, low store select a write, at timing_pos.
// RL5: Write words and lane masks are captured on both input timing edges.
// RL6: Read words launch on output timing edges, or input edges when both held high.
// RL7: Both selects are captured only on the input_timing_pos rising edge.
// RL8: The read bus stays released while powering up.
// RL9: Host should park all four clocks at one level when stopping them; host model parks output clocks low only when follow is set.
// RL10: Each write word uses the mask captured together with that word.
// RL11: Read bus is released at the output edge that finds no read data buffered.
// RL12: Reads hitting a pending write return the new write data.
// RL13: First read word comes after the next timing_pos edge following the request.
// RL14: Host presents the write address at the following input_timing_neg edge.
// RL15: Host drives write word0 at the starting pos edge, word1 at next neg edge.
// RL16: Pending work on a port completes even if the port is then deselected.
// RL17: Masked lanes keep stored bits; forwarded data merges written lanes with old.
`timescale 1ns/1ps
`default_nettype none
module dpsr_top
	import dpsr_pkg::*;
(
	input wire logic clk, // 20 MHz system clock
	input wire logic rst_b, // Asynchronous reset, active low
	input wire logic input_timing_pos, // Input timing clock, true
	input wire logic input_timing_neg, // Input timing clock, complement
	input wire logic output_timing_pos, // Output timing clock, true
	input wire logic output_timing_neg, // Output timing clock, complement
	input wire logic fetch_sel_n, // Read port select, active low
	input wire logic store_sel_n, // Write port select, active low
	input wire logic [ADDR_W-1:0] addr, // Shared burst address
	input wire logic [DATA_W-1:0] write_bus, // Write data
	input wire logic lane0_wr_mask, // Lane 0 write mask, active low
	input wire logic lane1_wr_mask, // Lane 1 write mask, active low
	input wire logic lane2_wr_mask, // Lane 2 write mask, active low
	input wire logic lane3_wr_mask, // Lane 3 write mask, active low
	output logic [DATA_W-1:0] read_bus, // Read data
	output logic read_bus_oe // Read bus drive enable
);
	typedef struct packed {
		logic [2:0] k, kn, c, cn, warm;
		logic [1:0] rsel, wsel;
		logic [ADDR_W-1:0] a1, a2;
		logic [DATA_W-1:0] d1, d2;
		logic [LANES-1:0] m1, m2;
		logic rd_req;
		logic [ADDR_W-1:0] rd_addr;
		dpsr_rp_t rp;
		logic [DATA_W-1:0] rw0, rw1;
		dpsr_wr_t wr;
		logic [DATA_W-1:0] cap_d0;
		logic [LANES-1:0] cap_m0;
		logic wp_valid;
		logic [ADDR_W-1:0] w_addr;
		logic [DATA_W-1:0] w_d0, w_d1;
		logic [LANES-1:0] w_m0, w_m1;
		logic [DATA_W-1:0] b0, b1;
		logic [CNT_W-1:0] cnt;
		logic [DATA_W-1:0] dout;
		logic oe;
	} dpsr_st_t;

	logic [1:0] rst_sync;
	logic rst_n;
	dpsr_st_t st, next_st;
	logic [DATA_W-1:0] mem [0:(1<<WORD_ADDR_W)-1];
	logic kp, kneg, cp, cneg, use_k, oedge_p, oedge_n, oedge;
	logic hit;
	logic [DATA_W-1:0] arr0, arr1, fw0, fw1, head;
	logic push_ok;
	logic mem_we;

	function automatic logic [DATA_W-1:0] dpsr_merge(input logic [DATA_W-1:0] old,
			input logic [DATA_W-1:0] nw, input logic [LANES-1:0] mask_n);
		logic [DATA_W-1:0] r;
		r = old;
		for (int i = 0; i < LANES; i++) begin
			if (!mask_n[i]) begin
				r[i*LANE_W +: LANE_W] = nw[i*LANE_W +: LANE_W];
			end
		end
		return r;
	endfunction

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'h1};
		end
	end
	assign rst_n = rst_sync[1];

	// Rising edges seen after the two-flop synchronisers; ignored until the detect
	// stage has refilled after reset, so a clock already high is not taken as a rise
	assign kp = st.k[1] & ~st.k[2] & st.warm[2];
	assign kneg = st.kn[1] & ~st.kn[2] & st.warm[2];
	assign cp = st.c[1] & ~st.c[2] & st.warm[2];
	assign cneg = st.cn[1] & ~st.cn[2] & st.warm[2];
	assign use_k = st.c[1] & st.cn[1]; // RL6
	assign oedge_p = use_k ? kp : cp; // RL6
	assign oedge_n = use_k ? kneg : cneg; // RL6
	assign oedge = oedge_p | oedge_n;

	assign arr0 = mem[{st.rd_addr, BURST_OFS0}]; // RL2
	assign arr1 = mem[{st.rd_addr, BURST_OFS1}]; // RL2
	assign hit = st.wp_valid && (st.w_addr == st.rd_addr);
	assign fw0 = hit ? dpsr_merge(arr0, st.w_d0, st.w_m0) : arr0; // RL12 RL17
	assign fw1 = hit ? dpsr_merge(arr1, st.w_d1, st.w_m1) : arr1; // RL12 RL17
	assign head = st.b0;
	assign push_ok = (st.cnt != CNT_FULL) || oedge;
	assign mem_we = kp && st.wp_valid;

	always_comb begin
		logic do_push, do_pop;
		logic [DATA_W-1:0] pw;
		do_push = 1'b0;
		do_pop = 1'b0;
		pw = st.rw0;
		next_st = st;
		next_st.k = {st.k[1:0], input_timing_pos};
		next_st.kn = {st.kn[1:0], input_timing_neg};
		next_st.c = {st.c[1:0], output_timing_pos};
		next_st.cn = {st.cn[1:0], output_timing_neg};
		next_st.warm = {st.warm[1:0], 1'b1};
		next_st.rsel = {st.rsel[0], fetch_sel_n};
		next_st.wsel = {st.wsel[0], store_sel_n};
		next_st.a1 = addr;
		next_st.a2 = st.a1;
		next_st.d1 = write_bus;
		next_st.d2 = st.d1;
		next_st.m1 = {lane3_wr_mask, lane2_wr_mask, lane1_wr_mask, lane0_wr_mask};
		next_st.m2 = st.m1;
		// Read sequencer; independent of the write side
		case (st.rp) // RL3
			RP_W0: begin
				pw = st.rw0;
				do_push = push_ok;
				if (push_ok) next_st.rp = RP_W1;
			end
			RP_W1: begin
				pw = st.rw1;
				do_push = push_ok;
				if (push_ok) next_st.rp = RP_IDLE;
			end
			default: begin
				next_st.rp = RP_IDLE;
			end
		endcase
		if (kp) begin
			if (st.rd_req) begin
				next_st.rw0 = fw0; // RL13 RL16
				next_st.rw1 = fw1;
				next_st.rp = RP_W0;
			end
			next_st.rd_req = ~st.rsel[1]; // RL4 RL7
			next_st.rd_addr = st.a2;
		end
		// Write sequencer
		if (kp && st.wp_valid) begin
			next_st.wp_valid = 1'b0; // Committed to the array this edge
		end
		case (st.wr)
			WR_ADDR: begin
				if (kneg) begin
					next_st.w_addr = st.a2; // RL14
					next_st.w_d0 = st.cap_d0; // RL10
					next_st.w_m0 = st.cap_m0;
					next_st.w_d1 = st.d2; // RL5 RL15
					next_st.w_m1 = st.m2; // RL10
					next_st.wp_valid = 1'b1; // RL16
					next_st.wr = WR_IDLE;
				end
			end
			default: begin
				next_st.wr = WR_IDLE;
			end
		endcase
		if (kp && !st.wsel[1]) begin // RL4 RL7
			next_st.cap_d0 = st.d2; // RL5 RL15
			next_st.cap_m0 = st.m2;
			next_st.wr = WR_ADDR;
		end
		// Output launch stage with two-entry buffer
		if (oedge) begin
			if (st.cnt != CNT_EMPTY) begin
				do_pop = 1'b1;
				next_st.dout = head;
				next_st.oe = 1'b1;
			end else begin
				next_st.oe = 1'b0; // RL11
			end
		end
		if (do_pop) begin
			next_st.b0 = st.b1;
		end
		if (do_push) begin
			if (st.cnt == CNT_EMPTY || (st.cnt == CNT_ONE && do_pop)) begin
				next_st.b0 = pw;
			end else begin
				next_st.b1 = pw;
			end
		end
		if (do_push && !do_pop) begin
			next_st.cnt = st.cnt + CNT_ONE;
		end else if (do_pop && !do_push) begin
			next_st.cnt = st.cnt - CNT_ONE;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0; // RL8
		end else begin
			st <= next_st;
		end
	end

	// Pending write enters the array at the next timing_pos edge
	always_ff @(posedge clk) begin
		if (mem_we) begin
			mem[{st.w_addr, BURST_OFS0}] <= dpsr_merge(mem[{st.w_addr, BURST_OFS0}],
				st.w_d0, st.w_m0); // RL1 RL17
			mem[{st.w_addr, BURST_OFS1}] <= dpsr_merge(mem[{st.w_addr, BURST_OFS1}],
				st.w_d1, st.w_m1); // RL1 RL17
		end
	end

	assign read_bus = st.dout;
	assign read_bus_oe = st.oe;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_rd_req;
		kp && !st.rsel[1];
	endsequence
	sequence s_wr_req;
		kp && !st.wsel[1];
	endsequence

	a_rd_start: assert property (s_rd_req |=> st.rd_req && st.rd_addr == $past(st.a2)) // RL4
		else $error("read request not captured");
	a_wr_start: assert property (s_wr_req |=> st.wr == WR_ADDR && st.cap_d0 == $past(st.d2)) // RL15
		else $error("write start or word0 not captured");
	a_wr_addr: assert property (kneg && st.wr == WR_ADDR |=> st.wp_valid
			&& st.w_addr == $past(st.a2) && st.w_m1 == $past(st.m2)) // RL14
		else $error("write address or word1 mask not captured");
	a_rd_latency: assert property (kp && st.rd_req |=> st.rp == RP_W0 && st.rw0 == $past(fw0)) // RL13
		else $error("read data not staged after next edge");
	a_fwd_lane: assert property (hit && !st.w_m0[0] |-> fw0[LANE_W-1:0] == st.w_d0[LANE_W-1:0]) // RL12
		else $error("forwarded lane 0 not taken from write data");
	a_mask_keep: assert property (hit && st.w_m1[LANES-1]
			|-> fw1[DATA_W-1 -: LANE_W] == arr1[DATA_W-1 -: LANE_W]) // RL17
		else $error("masked lane altered in forwarded data");
	a_oe_release: assert property (oedge && st.cnt == CNT_EMPTY |=> !st.oe) // RL11
		else $error("read bus not released after idle edge");
	a_out_launch: assert property (oedge && st.cnt != CNT_EMPTY |=> st.oe
			&& st.dout == $past(head)) // RL6
		else $error("buffered word not launched on output edge");
	a_commit: assert property (kp && st.wp_valid && !(kneg && st.wr == WR_ADDR)
			|=> !st.wp_valid) // RL16
		else $error("pending write not committed");
	a_pwr_hiz: assert property (@(posedge clk) disable iff (1'b0) !rst_n |=> !st.oe) // RL8
		else $error("read bus driven during reset");
endmodule
`default_nettype wire

// ### dv/dpsr_host.sv
// Host controller model: timing clocks, selects, address, write data
`timescale 1ns/1ps
`default_nettype none
module dpsr_host
	import dpsr_pkg::*;
(
	input wire logic clk, // System clock
	input wire logic follow, // Output clocks copy input clocks
	input wire logic park, // Stop input timing clocks low; output clocks too only when follow is set
	input wire logic [2*ADDR_W+2*DATA_W+2*LANES+1:0] req, // Request of next period
	output logic input_timing_pos, // K true
	output logic input_timing_neg, // K complement
	output logic output_timing_pos, // Output clock true
	output logic output_timing_neg, // Output clock complement
	output logic fetch_sel_n, // Read select
	output logic store_sel_n, // Write select
	output logic [ADDR_W-1:0] addr, // Address
	output logic [DATA_W-1:0] write_bus, // Write data
	output logic [LANES-1:0] mask, // Lane masks
	output logic [3:0] ph, // Phase in period
	output int kc // Period count
);
	logic rd, wr;
	logic [ADDR_W-1:0] ra, wa;
	logic [DATA_W-1:0] d0, d1;
	logic [LANES-1:0] m0, m1;
	assign {rd, wr, ra, wa, d0, d1, m0, m1} = req;
	// Both held high selects the input clocks as output timing
	assign output_timing_pos = follow ? input_timing_pos : 1'h1;
	assign output_timing_neg = follow ? input_timing_neg : 1'h1;
	initial begin
		{ph, kc, input_timing_pos, addr, write_bus} = '0;
		{input_timing_neg, fetch_sel_n, store_sel_n, mask} = '1;
	end
	always @(posedge clk) begin
		ph <= (ph == 4'h9) ? 4'h0 : ph + 4'h1;
		if (ph == 4'h9)
			kc <= kc + 1;
		case (ph)
		4'h0: begin
			fetch_sel_n <= !rd;
			store_sel_n <= !wr;
			addr <= ra;
			write_bus <= d0;
			mask <= m0;
		end
		4'h1: {input_timing_pos, input_timing_neg} <= park ? 2'h0 : 2'h2;
		4'h5: begin
			{fetch_sel_n, store_sel_n} <= 2'h3;
			addr <= wa;
			write_bus <= d1;
			mask <= m1;
		end
		4'h6: {input_timing_pos, input_timing_neg} <= park ? 2'h0 : 2'h1;
		default: ;
		endcase
	end
endmodule
`default_nettype wire

// ### dv/dual_port_ddr_burst2_sram_bench.sv
// Self-checking bench of the dual port burst SRAM with a host model
`timescale 1ns/1ps
`default_nettype none
module dual_port_ddr_burst2_sram_bench
	import dpsr_pkg::*;
;
	typedef struct packed {
		logic r, w;
		logic [ADDR_W-1:0] ra, wa;
		logic [DATA_W-1:0] x0, x1;
		logic [LANES-1:0] k0, k1;
	} dpsr_row_t;
	logic clk = 1'h0;
	logic rst_b = 1'h0;
	logic follow = 1'h0;
	logic park = 1'h0;
	dpsr_row_t cur = '0;
	logic input_timing_pos, input_timing_neg, output_timing_pos, output_timing_neg;
	logic fetch_sel_n, store_sel_n, read_bus_oe;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] write_bus, read_bus;
	logic [LANES-1:0] mask;
	logic [3:0] ph;
	int kc, s;
	int n_mismatch = 0;
	int n_compared = 0;
	int ncyc = 0;
	bit [DATA_W:0] e;
	bit [DATA_W:0] e2 [256];
	bit [DATA_W:0] e7 [256];
	logic [DATA_W-1:0] mem [logic [WORD_ADDR_W-1:0]];
	dpsr_row_t rows [6] = '{
		'{1'h0, 1'h1, 18'h0, 18'h10, 36'h123456789, 36'hFEDCBA987, 4'h0, 4'h0},
		'{1'h1, 1'h1, 18'h10, 18'h11, 36'hAAAAAAAAA, 36'h555555555, 4'h0, 4'h0},
		'{1'h1, 1'h1, 18'h10, 18'h10, 36'h000000000, 36'hFFFFFFFFF, 4'h2, 4'h9},
		'{1'h1, 1'h0, 18'h10, 18'h0, 36'h0, 36'h0, 4'h0, 4'h0},
		'{1'h0, 1'h0, 18'h0, 18'h10, 36'h0DEADBEEF, 36'h0, 4'h0, 4'h0},
		'{1'h1, 1'h0, 18'h11, 18'h0, 36'h0, 36'h0, 4'h0, 4'h0}
	};
	always #25 clk = !clk;
	dpsr_host dpsr_host_i (.clk, .follow, .park, .req(cur), .input_timing_pos,
		.input_timing_neg, .output_timing_pos, .output_timing_neg, .fetch_sel_n,
		.store_sel_n, .addr,
		.write_bus, .mask, .ph, .kc);
	dpsr_top dpsr_top_i (.clk, .rst_b, .input_timing_pos, .input_timing_neg,
		.output_timing_pos, .output_timing_neg, .fetch_sel_n, .store_sel_n, .addr,
		.write_bus, .lane0_wr_mask(mask[0]), .lane1_wr_mask(mask[1]),
		.lane2_wr_mask(mask[2]), .lane3_wr_mask(mask[3]), .read_bus, .read_bus_oe);
	task automatic err(input string m);
		n_mismatch++;
		$display("ERROR %0t %s", $time, m);
	endtask
	task automatic complete_run();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	function automatic logic [DATA_W-1:0] mrg(input logic [DATA_W-1:0] o,
		input logic [DATA_W-1:0] n, input logic [LANES-1:0] k);
		mrg = o;
		for (int i = 0; i < LANES; i++)
			if (!k[i])
				mrg[i*LANE_W +: LANE_W] = n[i*LANE_W +: LANE_W];
	endfunction
	// One request per timing period; expected read words land two periods later
	task automatic op(input dpsr_row_t q);
		@(posedge clk iff ph == 4'h9);
		cur <= q;
		s = kc + 1;
		if (q.w) begin
			mem[{q.wa, BURST_OFS0}] = mrg(mem[{q.wa, BURST_OFS0}], q.x0, q.k0);
			mem[{q.wa, BURST_OFS1}] = mrg(mem[{q.wa, BURST_OFS1}], q.x1, q.k1);
		end
		if (q.r) begin
			e2[s + 2] = {1'h1, mem[{q.ra, BURST_OFS0}]};
			e7[s + 2] = {1'h1, mem[{q.ra, BURST_OFS1}]};
		end
	endtask
	always @(negedge clk) begin
		if (!rst_b) begin
			n_compared++;
			if (read_bus_oe !== 1'h0) err("read bus driven in reset");
		end else if (ph == 4'h2 || ph == 4'h7) begin
			e = (ph == 4'h2) ? e2[kc] : e7[kc];
			n_compared++;
			if (read_bus_oe !== e[DATA_W] || (e[DATA_W] && read_bus !== e[DATA_W-1:0]))
				err("read port word");
		end
	end
	always @(posedge clk) begin
		ncyc++;
		if (ncyc == 2000) begin
			err("timeout");
			complete_run();
		end
	end
	initial begin
		repeat (12) @(posedge clk);
		rst_b <= 1'h1;
		repeat (2) op('0);
		foreach (rows[i])
			op(rows[i]);
		repeat (4) op('0);
		follow <= 1'h1;
		op(rows[3]);
		op(rows[5]);
		repeat (4) op('0);
		rst_b <= 1'h0;
		repeat (12) @(posedge clk);
		rst_b <= 1'h1;
		park <= 1'h1;
		repeat (2) op('0);
		park <= 1'h0;
		op('0);
		op(rows[5]);
		repeat (4) op('0);
		complete_run();
	end
endmodule
`default_nettype wire
